// ===== design/ambient_zone_ramp_regs.sv
// ambient sensing config, ramp rate and zone status registers
`timescale 1ns/100ps
`default_nettype none
module ambient_zone_ramp_regs
   import azr_pkg::*;
#(
   parameter int AVG_TICK_CYCLES  = AVG_TICK_CYC,
   parameter int STEP_SLOW_CYCLES = STEP_SLOW_CYC
) (
   input  wire logic       clock_in,
   input  wire logic       srst_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic [7:0] light_input_a_in,
   input  wire logic [7:0] light_input_b_in,
   input  wire logic [7:0] zone_limit_0_in,
   input  wire logic [7:0] zone_limit_1_in,
   input  wire logic [7:0] zone_limit_2_in,
   input  wire logic [7:0] zone_limit_3_in,
   input  wire logic [6:0] zone_target_0_in,
   input  wire logic [6:0] zone_target_1_in,
   input  wire logic [6:0] zone_target_2_in,
   input  wire logic [6:0] zone_target_3_in,
   input  wire logic [6:0] zone_target_4_in,
   input  wire logic [6:0] brightness_code_in,
   output logic      [6:0] led_code_out,
   input  wire logic       int_n_in,
   output logic            int_n_out,
   output logic            int_n_oe_out
);
   logic [7:0]  cfg_r;
   logic [7:0]  ramp_r;
   logic        flag_r;
   logic [2:0]  zone_r;
   logic [7:0]  rdata_r;
   logic [7:0]  a_meta_r;
   logic [7:0]  a_sync_r;
   logic [7:0]  b_meta_r;
   logic [7:0]  b_sync_r;
   logic [7:0]  a_prev_r;
   logic [7:0]  b_prev_r;
   logic [7:0]  a_val_r;
   logic [7:0]  b_val_r;
   logic [7:0]  src_val;
   logic [8:0]  src_sum;
   logic [1:0]  src_sel;
   logic [1:0]  mode;
   logic        sense_en;
   logic        zone_drive;
   logic [12:0] acc_r;
   logic [4:0]  samp_cnt_r;
   logic [12:0] acc_nxt;
   logic [7:0]  avg_val;
   logic        avg_tick;
   logic        window_done;
   logic [2:0]  zone_nxt;
   logic        zone_update;
   logic        zone_read;
   logic        wr_cfg;
   logic        wr_ramp;
   logic [31:0] avg_period;
   logic [31:0] step_period;
   logic        step_tick;
   logic [6:0]  target;
   logic [6:0]  led_r;
   logic        rising;

   function automatic logic [31:0] step_cycles(input logic [2:0] code);
      if (code == 3'h0) begin
         step_cycles = 32'(STEP_FAST_CYC);
      end else begin
         step_cycles = 32'(STEP_SLOW_CYCLES) << (code - 3'h1);
      end
   endfunction : step_cycles

   function automatic logic [2:0] zone_of(input logic [7:0] v,
                                          input logic [7:0] l0,
                                          input logic [7:0] l1,
                                          input logic [7:0] l2,
                                          input logic [7:0] l3);
      if (v < l0) begin
         zone_of = 3'h0;
      end else if (v < l1) begin
         zone_of = 3'h1;
      end else if (v < l2) begin
         zone_of = 3'h2;
      end else if (v < l3) begin
         zone_of = 3'h3;
      end else begin
         zone_of = ZONE_TOP;
      end
   endfunction : zone_of

   // register access decode
   assign wr_cfg    = reg_wr_in && reg_addr_in == CFG_ADDR;
   assign wr_ramp   = reg_wr_in && reg_addr_in == RAMP_ADDR;
   assign zone_read = reg_rd_in && reg_addr_in == ZONE_ADDR;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cfg_r <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_r <= {1'b0, reg_wdata_in[6:0]};
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ramp_r <= RAMP_RESET;
      end else if (wr_ramp) begin
         ramp_r <= {2'b00, reg_wdata_in[5:0]};
      end
   end

   // reads return the value seen in the read cycle, one cycle later
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rdata_r <= UNMAPPED_DATA;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            CFG_ADDR:  rdata_r <= cfg_r;
            RAMP_ADDR: rdata_r <= ramp_r;
            ZONE_ADDR: rdata_r <= {4'h0, flag_r, zone_r};
            default:   rdata_r <= UNMAPPED_DATA;
         endcase
      end
   end
   assign reg_rdata_out = rdata_r;

   // sensor inputs come from another domain
   always_ff @(posedge clock_in) begin
      a_meta_r <= light_input_a_in;
      a_sync_r <= a_meta_r;
      b_meta_r <= light_input_b_in;
      b_sync_r <= b_meta_r;
   end

   // a word caught mid-change could mix old and new bits, so it is taken
   // only once two synchronised samples agree; a level that never settles
   // is never taken
   always_ff @(posedge clock_in) begin
      a_prev_r <= a_sync_r;
      b_prev_r <= b_sync_r;
      if (a_sync_r == a_prev_r) begin
         a_val_r <= a_sync_r;
      end
      if (b_sync_r == b_prev_r) begin
         b_val_r <= b_sync_r;
      end
   end

   assign src_sel    = cfg_r[SRC_LSB +: 2];
   assign mode       = cfg_r[MODE_LSB +: 2];
   assign sense_en   = mode == MODE_SENSE_ONLY || mode == MODE_ZONE_DRIVE;
   assign zone_drive = mode == MODE_ZONE_DRIVE;
   assign src_sum    = {1'b0, a_val_r} + {1'b0, b_val_r};

   always_comb begin
      case (src_sel)
         SRC_MEAN: src_val = src_sum[8:1];
         SRC_A:    src_val = a_val_r;
         SRC_B:    src_val = b_val_r;
         SRC_MAX:  src_val = (a_val_r > b_val_r) ? a_val_r : b_val_r;
         default:  src_val = a_val_r;
      endcase
   end

   // 32 evenly spaced samples per window, so the mean is a shift
   assign avg_period = 32'(AVG_TICK_CYCLES) << cfg_r[AVG_LSB +: 3];

   azr_step_timer #(.CW(32)) u_avg_timer (
      .clock_in  (clock_in),
      .srst_in   (srst_in),
      .run_in    (sense_en),
      .period_in (avg_period),
      .tick_out  (avg_tick)
   );

   assign acc_nxt     = acc_r + {5'h00, src_val};
   assign window_done = avg_tick && samp_cnt_r == 5'h1f;
   assign avg_val     = acc_nxt[12:AVG_SAMPLES_LOG2];

   always_ff @(posedge clock_in) begin
      if (srst_in || !sense_en) begin
         acc_r      <= '0;
         samp_cnt_r <= '0;
      end else if (window_done) begin
         acc_r      <= '0;
         samp_cnt_r <= '0;
      end else if (avg_tick) begin
         acc_r      <= acc_nxt;
         samp_cnt_r <= samp_cnt_r + 5'h01;
      end
   end

   assign zone_nxt    = zone_of(avg_val, zone_limit_0_in, zone_limit_1_in,
                                zone_limit_2_in, zone_limit_3_in);
   assign zone_update = window_done && zone_nxt != zone_r;

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         zone_r <= ZONE_RESET[ZCODE_LSB +: 3];
      end else if (zone_update) begin
         zone_r <= zone_nxt;
      end
   end

   // a change in the read cycle wins, so no zone event is lost
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         flag_r <= ZONE_RESET[FLAG_BIT];
      end else if (zone_update) begin
         flag_r <= 1'b1;
      end else if (zone_read) begin
         flag_r <= 1'b0;
      end
   end

   // open drain: only ever pull low, the line floats when released
   assign int_n_out    = 1'b0;
   assign int_n_oe_out = flag_r;

   always_comb begin
      if (!zone_drive) begin
         target = brightness_code_in;
      end else begin
         case (zone_r)
            3'h0:    target = zone_target_0_in;
            3'h1:    target = zone_target_1_in;
            3'h2:    target = zone_target_2_in;
            3'h3:    target = zone_target_3_in;
            default: target = zone_target_4_in;
         endcase
      end
   end

   assign rising      = target > led_r;
   assign step_period = rising ? step_cycles(ramp_r[RISE_LSB +: 3])
                               : step_cycles(ramp_r[FALL_LSB +: 3]);

   azr_step_timer #(.CW(32)) u_step_timer (
      .clock_in  (clock_in),
      .srst_in   (srst_in),
      .run_in    (target != led_r),
      .period_in (step_period),
      .tick_out  (step_tick)
   );

   // one code per step keeps the ramp time proportional to distance
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         led_r <= '0;
      end else if (step_tick) begin
         led_r <= rising ? led_r + 7'h01 : led_r - 7'h01;
      end
   end
   assign led_code_out = led_r;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);

   sequence s_zone_event;
      zone_update;
   endsequence
   sequence s_zone_ack;
      zone_read && !zone_update;
   endsequence

   a_update_pulls_int: assert property (
      s_zone_event |=> int_n_oe_out && flag_r && !int_n_out)
      else $error("zone update did not pull interrupt low");
   a_read_releases_int: assert property (
      s_zone_ack |=> !int_n_oe_out)
      else $error("zone read did not release interrupt");
   a_flag_clear_read: assert property (
      s_zone_ack ##1 !zone_update |=> !flag_r)
      else $error("flag came back without a zone change");
   a_zone_in_range: assert property (
      zone_r <= ZONE_TOP)
      else $error("zone code out of range");
   a_zone_readback: assert property (
      zone_read |=> reg_rdata_out == {4'h0, $past(flag_r), $past(zone_r)})
      else $error("zone register read value wrong");
   a_zone_held_off: assert property (
      !sense_en |=> $stable(zone_r))
      else $error("zone changed while sensing off");
   a_ramp_write: assert property (
      wr_ramp |=> ramp_r == {2'b00, $past(reg_wdata_in[5:0])})
      else $error("ramp write not stored");
   a_source_max: assert property (
      src_sel == SRC_MAX |-> src_val >= a_val_r && src_val >= b_val_r)
      else $error("max source not the higher input");
   a_led_steps: assert property (
      led_r != $past(led_r) |-> $past(step_tick) &&
         (led_r - $past(led_r) == 7'h01 || $past(led_r) - led_r == 7'h01))
      else $error("led code moved without a single step");
   a_target_mode: assert property (
      !zone_drive |-> target == brightness_code_in)
      else $error("brightness code not used outside zone mode");
endmodule : ambient_zone_ramp_regs
`default_nettype wire

// ===== design/azr_pkg.sv
// constants shared by the ambient zone and ramp register block
package azr_pkg;
   localparam logic [7:0] CFG_ADDR      = 8'h20;
   localparam logic [7:0] RAMP_ADDR     = 8'h30;
   localparam logic [7:0] ZONE_ADDR     = 8'h40;
   localparam logic [7:0] CFG_RESET     = 8'h2c;
   localparam logic [7:0] RAMP_RESET    = 8'h00;
   localparam logic [7:0] ZONE_RESET    = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // field positions
   localparam int SRC_LSB   = 5;
   localparam int MODE_LSB  = 3;
   localparam int AVG_LSB   = 0;
   localparam int RISE_LSB  = 3;
   localparam int FALL_LSB  = 0;
   localparam int FLAG_BIT  = 3;
   localparam int ZCODE_LSB = 0;
   // source select and mode codes
   localparam logic [1:0] SRC_MEAN  = 2'h0;
   localparam logic [1:0] SRC_A     = 2'h1;
   localparam logic [1:0] SRC_B     = 2'h2;
   localparam logic [1:0] SRC_MAX   = 2'h3;
   localparam logic [1:0] MODE_SENSE_ONLY = 2'h1;
   localparam logic [1:0] MODE_ZONE_DRIVE = 2'h3;
   localparam logic [2:0] ZONE_TOP  = 3'h4;
   // timing
   localparam int CLK_MHZ       = 250;
   localparam int AVG_TICK_US   = 1000;
   localparam int AVG_TICK_CYC  = AVG_TICK_US * CLK_MHZ;
   localparam int AVG_SAMPLES_LOG2 = 5;
   localparam int STEP_FAST_NS  = 8000;
   localparam int STEP_FAST_CYC = (STEP_FAST_NS * CLK_MHZ) / 1000;
   localparam int STEP_SLOW_US  = 1024;
   localparam int STEP_SLOW_CYC = STEP_SLOW_US * CLK_MHZ;
endpackage : azr_pkg

// ===== design/azr_step_timer.sv
// interval timer, held cleared while run_in is low, producing one-cycle ticks
`timescale 1ns/100ps
`default_nettype none
module azr_step_timer #(
   parameter int CW = 32
) (
   input  wire logic          clock_in,
   input  wire logic          srst_in,
   input  wire logic          run_in,
   input  wire logic [CW-1:0] period_in,
   output logic               tick_out
);
   logic [CW-1:0] cnt_r;
   logic          at_end;

   // period changes take effect on the running count, no restart
   assign at_end   = (cnt_r >= period_in - CW'(1));
   assign tick_out = run_in && at_end;

   always_ff @(posedge clock_in) begin
      if (srst_in || !run_in) begin
         cnt_r <= '0;
      end else if (at_end) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   a_tick_spacing: assert property (@(posedge clock_in) disable iff (srst_in)
      tick_out && period_in > CW'(1) |=> !tick_out)
      else $error("timer ticked twice in a row");
endmodule : azr_step_timer
`default_nettype wire

// ===== verification/ambient_zone_ramp_regs_tb_top.sv
// self-checking bench for the ambient zone and ramp register block
`timescale 1ns/100ps
`default_nettype none
module ambient_zone_ramp_regs_tb_top;
   import azr_pkg::*;
   localparam int TICK = 4;
   // source, input a, input b, zone
   localparam logic [23:0] ZT [5] = '{24'h010701, 24'h170102, 24'h270a03,
                                      24'h3d0104, 24'h300000};
   // ramp byte, rising, cycles per step
   localparam logic [23:0] RT [5] = '{24'h091008, 24'h0a0010, 24'h111010,
                                      24'h3a1200, 24'h0017d0};
   logic        clock_in  = 1'b0;
   logic        srst_in   = 1'b1;
   logic [7:0]  la        = 8'h00;
   logic [7:0]  lb        = 8'h00;
   logic [6:0]  bright    = 7'h00;
   logic [6:0]  tgt [5]   = '{7'h10, 7'h30, 7'h08, 7'h28, 7'h18};
   logic [7:0]  lf        = 8'h30;
   logic [7:0]  expq [$];
   logic        pend      = 1'b0;
   logic [23:0] e;
   int          bad_count = 0;
   int          checked   = 0;
   int          n;
   int          w;
   wire  [7:0]  addr, wdata, rdata;
   wire         wr, rd, ion, ioe, iw;
   wire  [6:0]  led;
   always #2 clock_in = ~clock_in;
   ambient_zone_ramp_regs #(.AVG_TICK_CYCLES(TICK), .STEP_SLOW_CYCLES(8))
   u_dut (
      .clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .light_input_a_in(la), .light_input_b_in(lb),
      .zone_limit_0_in(8'h33), .zone_limit_1_in(8'h66),
      .zone_limit_2_in(8'h99), .zone_limit_3_in(8'hcc),
      .zone_target_0_in(tgt[0]), .zone_target_1_in(tgt[1]),
      .zone_target_2_in(tgt[2]), .zone_target_3_in(tgt[3]),
      .zone_target_4_in(tgt[4]), .brightness_code_in(bright),
      .led_code_out(led), .int_n_in(iw), .int_n_out(ion),
      .int_n_oe_out(ioe)
   );
   azr_host_model u_host (
      .clock_in(clock_in), .int_n_in(ion), .int_oe_in(ioe),
      .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
      .int_wire_out(iw)
   );
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nxt
   task automatic chk(input string s, input logic [15:0] x,
                      input logic [15:0] y);
      checked++;
      if (y !== x) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", s, x, y);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   task automatic rdx(input logic [7:0] a, input logic [7:0] x);
      expq.push_back(x);
      u_host.rd(a);
   endtask : rdx
   // any: wait for a change; else wait until led equals v
   task automatic wait_led(input logic [6:0] v, input bit any,
                           output int k);
      logic [6:0] old;
      old = led;
      k   = 0;
      while (any ? led === old : led !== v) begin
         @(posedge clock_in);
         #1;
         k++;
         if (k > 9000) begin
            chk("led timeout", 16'h0, 16'h1);
            results();
         end
      end
   endtask : wait_led
   task automatic wait_int(output int k);
      k = 0;
      while (iw !== 1'b0) begin
         @(posedge clock_in);
         #1;
         k++;
         if (k > 9000) begin
            chk("int timeout", 16'h0, 16'h1);
            results();
         end
      end
   endtask : wait_int
   // read data is registered, so it is judged one edge after the strobe
   always @(posedge clock_in) begin
      pend <= rd;
      if (pend) begin
         if (expq.size() == 0)
            chk("stray read", 16'h0, 16'h1);
         else
            chk("read data", {8'h00, expq.pop_front()},
                {8'h00, rdata});
      end
   end
   initial begin
      repeat (5) @(posedge clock_in);
      #1;
      srst_in = 1'b0;
      rdx(RAMP_ADDR, 8'h00);
      rdx(ZONE_ADDR, 8'h00);
      rdx(CFG_ADDR, CFG_RESET);
      rdx(8'h55, UNMAPPED_DATA);
      chk("int idle", 16'h1, {15'h0, iw});
      for (int i = 0; i < 4; i++) begin
         lf = nxt(lf);
         u_host.wr(RAMP_ADDR, lf);
         rdx(RAMP_ADDR, lf & 8'h3f);
         u_host.wr(ZONE_ADDR, lf);
         rdx(ZONE_ADDR, 8'h00);
      end
      u_host.wr(RAMP_ADDR, 8'h09);
      for (int i = 0; i < 5; i++) begin
         e = ZT[i];
         u_host.wr(CFG_ADDR, 8'h00);
         la = e[19:12];
         lb = e[11:4];
         // let the input synchronisers settle before sensing restarts
         repeat (3) @(posedge clock_in);
         u_host.wr(CFG_ADDR, {1'b0, e[21:20], MODE_ZONE_DRIVE, 3'(i % 3)});
         w = 32 * TICK << (i % 3);
         wait_int(n);
         chk("window", 16'h1, {15'h0, n + 2 >= w && n <= w + 8});
         rdx(ZONE_ADDR, {5'h01, e[2:0]});
         chk("int release", 16'h1, {15'h0, iw});
         rdx(ZONE_ADDR, {5'h00, e[2:0]});
         wait_led(tgt[e[2:0]], 1'b0, n);
      end
      for (int m = 0; m < 2; m++) begin
         u_host.wr(CFG_ADDR, 8'(m * 16));
         la = 8'hff;
         lb = 8'hff;
         bright = 7'h05 + 7'(m);
         repeat (400) @(posedge clock_in);
         #1;
         chk("int quiet", 16'h1, {15'h0, iw});
         rdx(ZONE_ADDR, 8'h00);
         wait_led(bright, 1'b0, n);
      end
      // sensing on but brightness code in charge: zone and flag move only
      u_host.wr(CFG_ADDR, {1'b0, SRC_A, MODE_SENSE_ONLY, 3'h0});
      wait_int(n);
      chk("window", 16'h1, {15'h0, n + 2 >= 32 * TICK && n <= 32 * TICK + 8});
      rdx(ZONE_ADDR, {5'h01, ZONE_TOP});
      repeat (40) @(posedge clock_in);
      #1;
      chk("sense only led", {9'h000, bright}, {9'h000, led});
      la = 8'h00;
      lb = 8'h00;
      u_host.wr(CFG_ADDR, 8'h28);
      // periods never shrink here, since the step timer is not restarted
      for (int i = 0; i < 5; i++) begin
         u_host.wr(RAMP_ADDR, RT[i][23:16]);
         bright = RT[i][12] ? led + 7'h04 : led - 7'h04;
         wait_led(7'h00, 1'b1, n);
         wait_led(7'h00, 1'b1, n);
         wait_led(7'h00, 1'b1, n);
         chk("step time", {4'h0, RT[i][11:0]}, 16'(n));
         wait_led(bright, 1'b0, n);
      end
      results();
   end
endmodule : ambient_zone_ramp_regs_tb_top
`default_nettype wire

// ===== verification/azr_host_model.sv
// host model: register strobes and the pulled-up interrupt wire
`timescale 1ns/100ps
`default_nettype none
module azr_host_model (
   input  wire logic       clock_in,
   input  wire logic       int_n_in,
   input  wire logic       int_oe_in,
   output logic      [7:0] addr_out,
   output logic            wr_out,
   output logic            rd_out,
   output logic      [7:0] wdata_out,
   output logic            int_wire_out
);
   // pull-up: the wire is high whenever the device lets go
   assign int_wire_out = int_oe_in ? int_n_in : 1'b1;
   initial begin
      addr_out  = 8'h00;
      wdata_out = 8'h00;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      #1;
      addr_out  = a;
      wdata_out = d;
      wr_out    = 1'b1;
      @(posedge clock_in);
      #1;
      wr_out    = 1'b0;
      // released lines flip so a stale value is never taken as live
      addr_out  = ~a;
      wdata_out = ~d;
   endtask : wr
   // a read of zone status is also the interrupt acknowledge
   task automatic rd(input logic [7:0] a);
      @(posedge clock_in);
      #1;
      addr_out = a;
      rd_out   = 1'b1;
      @(posedge clock_in);
      #1;
      rd_out   = 1'b0;
      addr_out = ~a;
   endtask : rd
endmodule : azr_host_model
`default_nettype wire
